// ==== hdl/fcs_pkg.sv ====
// Purpose: constants for the flash command sequencer host controller
// Assumes: one 200 MHz clock; device takes one write per asserted strobe
// Notes:   opcodes, counts and mode values as the sequencer expects them
package fcs_pkg;
    // mode-entry register values
    localparam logic [15:0] MODE_READ = 16'h0000;
    localparam logic [15:0] MODE_CODE = 16'h0001;
    localparam logic [15:0] MODE_DATA = 16'h0080;
    // command-area byte codes
    localparam logic [7:0] CB_PROG    = 8'he8;
    localparam logic [7:0] CB_BERASE  = 8'h20;
    localparam logic [7:0] CB_MERASE  = 8'h21;
    localparam logic [7:0] CB_SUSP    = 8'hb0;
    localparam logic [7:0] CB_CONFIRM = 8'hd0;
    localparam logic [7:0] CB_CLEAR   = 8'h50;
    localparam logic [7:0] CB_FSTOP   = 8'hb3;
    localparam logic [7:0] CB_BLANK   = 8'h71;
    localparam logic [7:0] CB_CONFIG  = 8'h40;
    // halfword counts
    localparam logic [7:0] CNT_CODE_PROG = 8'h40;
    localparam logic [7:0] CNT_DATA_PROG = 8'h02;
    localparam logic [7:0] CNT_CONFIG    = 8'h08;
    // user request codes
    localparam logic [3:0] OP_MODE   = 4'h0;
    localparam logic [3:0] OP_PROG   = 4'h1;
    localparam logic [3:0] OP_BERASE = 4'h2;
    localparam logic [3:0] OP_MERASE = 4'h3;
    localparam logic [3:0] OP_SUSP   = 4'h4;
    localparam logic [3:0] OP_RESUME = 4'h5;
    localparam logic [3:0] OP_CLEAR  = 4'h6;
    localparam logic [3:0] OP_FSTOP  = 4'h7;
    localparam logic [3:0] OP_BLANK  = 4'h8;
    localparam logic [3:0] OP_CONFIG = 4'h9;
    // kind of the last write issued
    localparam logic [2:0] WK_NONE  = 3'h0;
    localparam logic [2:0] WK_MODE  = 3'h1;
    localparam logic [2:0] WK_OPC   = 3'h2;
    localparam logic [2:0] WK_COUNT = 3'h3;
    localparam logic [2:0] WK_DATA  = 3'h4;
    localparam logic [2:0] WK_CONF  = 3'h5;
    // sequencer states, gray along idle-count-data-confirm
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_COUNT   = 2'b01,
        ST_DATA    = 2'b11,
        ST_CONFIRM = 2'b10
    } fcs_state_t;
endpackage

// ==== hdl/fcs_host_ctrl.sv ====
// Purpose: host-side driver of the flash command sequencer write port
// Assumes: device inputs synchronous to sys_clk; one write per strobe
// Notes:   refuses requests the device would reject, to avoid a lock, save a resume with nothing suspended
`timescale 1ns/1ps
module fcs_host_ctrl
    import fcs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        req_valid,
    input  wire logic [3:0]  req_op,
    input  wire logic [15:0] req_mode,
    output logic             req_ready,
    output logic             req_done,
    output logic             req_refused,
    input  wire logic        wd_valid,
    input  wire logic [15:0] wd_data,
    output logic             wd_ready,
    output logic             dev_wr_en,
    output logic             dev_wr_mode,
    output logic [15:0]      dev_wr_data,
    input  wire logic        dev_ready,
    input  wire logic        dev_cmd_lock,
    output logic [15:0]      cur_mode
);
    fcs_state_t  st_ff, nxt_st;
    logic        req_ready_ff, req_done_ff, req_refused_ff, wd_ready_ff;
    logic        wr_en_ff, wr_mode_ff;
    logic [15:0] wr_data_ff, mode_ff;
    logic [3:0]  op_ff;
    logic [7:0]  cnt_ff, tgt_ff;
    logic [2:0]  wk_ff;
    logic        accept, legal, take_wd;
    logic        rdy_prev_ff;

    // every check below runs on sys_clk and sleeps through reset
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // decide whether the device would accept this request now
    function automatic logic op_legal(input logic [3:0]  op,
                                      input logic [15:0] md,
                                      input logic [15:0] nmd,
                                      input logic        lock,
                                      input logic        rdy);
        logic ok;
        ok = 1'b1;
        if (op == OP_MODE)
            ok = rdy && (nmd == MODE_READ || nmd == MODE_CODE
                         || nmd == MODE_DATA);
        else if (op > OP_CONFIG)
            ok = 1'b0;
        else if (md == MODE_READ)
            ok = 1'b0;
        else if (lock && op != OP_CLEAR && op != OP_FSTOP)
            ok = 1'b0;
        else if (!rdy && op != OP_SUSP && op != OP_FSTOP)
            ok = 1'b0;
        else if (md == MODE_CODE && (op == OP_MERASE || op == OP_BLANK))
            ok = 1'b0;
        else if (md == MODE_DATA && op == OP_CONFIG)
            ok = 1'b0;
        return ok;
    endfunction

    // first byte written for each command
    function automatic logic [7:0] first_byte(input logic [3:0] op);
        logic [7:0] b;
        b = CB_CONFIRM;
        case (op)
            OP_PROG:   b = CB_PROG;
            OP_BERASE: b = CB_BERASE;
            OP_MERASE: b = CB_MERASE;
            OP_SUSP:   b = CB_SUSP;
            OP_RESUME: b = CB_CONFIRM;
            OP_CLEAR:  b = CB_CLEAR;
            OP_FSTOP:  b = CB_FSTOP;
            OP_BLANK:  b = CB_BLANK;
            OP_CONFIG: b = CB_CONFIG;
            default:   b = CB_CONFIRM;
        endcase
        return b;
    endfunction

    assign legal   = op_legal(req_op, mode_ff, req_mode, dev_cmd_lock,
                              dev_ready);
    assign accept  = req_valid && req_ready_ff && st_ff == ST_IDLE;
    assign take_wd = st_ff == ST_DATA && wd_valid && wd_ready_ff;

    // next state of the write sequencer
    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE:
            begin
                if (accept && legal)
                begin
                    case (req_op)
                        OP_PROG, OP_CONFIG:
                            nxt_st = ST_COUNT;
                        OP_BERASE, OP_MERASE, OP_BLANK:
                            nxt_st = ST_CONFIRM;
                        default:
                            nxt_st = ST_IDLE;
                    endcase
                end
            end
            ST_COUNT:
                nxt_st = ST_DATA;
            ST_DATA:
            begin
                if (take_wd && cnt_ff == tgt_ff - 8'h01)
                    nxt_st = ST_CONFIRM;
            end
            ST_CONFIRM:
                nxt_st = ST_IDLE;
            default:
                nxt_st = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            st_ff <= ST_IDLE;
        else
            st_ff <= nxt_st;
    end

    // latched request and halfword count target
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            op_ff  <= OP_MODE;
            tgt_ff <= 8'h00;
        end
        else if (accept && legal)
        begin
            op_ff <= req_op;
            if (req_op == OP_CONFIG)
                tgt_ff <= CNT_CONFIG;
            else if (mode_ff == MODE_CODE)
                tgt_ff <= CNT_CODE_PROG;
            else
                tgt_ff <= CNT_DATA_PROG;
        end
    end

    // halfword counter
    always_ff @(posedge sys_clk)
    begin
        if (rst || st_ff == ST_COUNT)
            cnt_ff <= 8'h00;
        else if (take_wd)
            cnt_ff <= cnt_ff + 8'h01;
    end

    // mode tracking; register written only on a real change
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            mode_ff <= MODE_READ;
        else if (accept && legal && req_op == OP_MODE)
            mode_ff <= req_mode;
    end

    // last ready level; a rise is the completion event that the device
    // reports as its ready interrupt, reset high to match the idle level
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            rdy_prev_ff <= 1'b1;
        else
            rdy_prev_ff <= dev_ready;
    end

    // device write port
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_en_ff   <= 1'b0;
            wr_mode_ff <= 1'b0;
            wr_data_ff <= 16'h0000;
            wk_ff      <= WK_NONE;
        end
        else
        begin
            wr_en_ff   <= 1'b0;
            wr_mode_ff <= 1'b0;
            wk_ff      <= WK_NONE;
            case (st_ff)
                ST_IDLE:
                begin
                    if (accept && legal && req_op == OP_MODE)
                    begin
                        if (req_mode != mode_ff)
                        begin
                            wr_en_ff   <= 1'b1;
                            wr_mode_ff <= 1'b1;
                            wr_data_ff <= req_mode;
                            wk_ff      <= WK_MODE;
                        end
                    end
                    else if (accept && legal)
                    begin
                        wr_en_ff   <= 1'b1;
                        wr_data_ff <= {8'h00, first_byte(req_op)};
                        wk_ff      <= WK_OPC;
                    end
                end
                ST_COUNT:
                begin
                    wr_en_ff   <= 1'b1;
                    wr_data_ff <= {8'h00, tgt_ff};
                    wk_ff      <= WK_COUNT;
                end
                ST_DATA:
                begin
                    if (take_wd)
                    begin
                        wr_en_ff   <= 1'b1;
                        wr_data_ff <= wd_data;
                        wk_ff      <= WK_DATA;
                    end
                end
                ST_CONFIRM:
                begin
                    wr_en_ff   <= 1'b1;
                    wr_data_ff <= {8'h00, CB_CONFIRM};
                    wk_ff      <= WK_CONF;
                end
                default:
                    wr_en_ff <= 1'b0;
            endcase
        end
    end

    // user handshake flags
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            req_ready_ff   <= 1'b0;
            req_done_ff    <= 1'b0;
            req_refused_ff <= 1'b0;
            wd_ready_ff    <= 1'b0;
        end
        else
        begin
            req_ready_ff   <= nxt_st == ST_IDLE;
            req_refused_ff <= accept && !legal;
            req_done_ff    <= (accept && legal && nxt_st == ST_IDLE)
                              || st_ff == ST_CONFIRM;
            wd_ready_ff    <= nxt_st == ST_DATA && !(take_wd
                              && cnt_ff == tgt_ff - 8'h01);
        end
    end

    assign req_ready   = req_ready_ff;
    assign req_done    = req_done_ff;
    assign req_refused = req_refused_ff;
    assign wd_ready    = wd_ready_ff;
    assign dev_wr_en   = wr_en_ff;
    assign dev_wr_mode = wr_mode_ff;
    assign dev_wr_data = wr_data_ff;
    assign cur_mode    = mode_ff;

    // write of an opcode byte with a given value
    sequence s_opc(logic [7:0] b);
        wk_ff == WK_OPC && wr_data_ff == {8'h00, b};
    endsequence

    sequence s_conf;
        wk_ff == WK_CONF && wr_data_ff == {8'h00, CB_CONFIRM};
    endsequence

    chk_mode_write_change: assert property (
        wk_ff == WK_MODE |-> wr_data_ff != $past(mode_ff)
                             && wr_data_ff == mode_ff)
        else $error("mode register written without a change");

    chk_read_no_cmd: assert property (
        (wr_en_ff && !wr_mode_ff) |-> $past(mode_ff) != MODE_READ)
        else $error("command write issued in read mode");

    chk_prog_count: assert property (
        s_opc(CB_PROG) |=> wk_ff == WK_COUNT
            && wr_data_ff[7:0] == (mode_ff == MODE_CODE ? CNT_CODE_PROG
                                                        : CNT_DATA_PROG))
        else $error("program count byte wrong or late");

    chk_erase_pair: assert property (
        s_opc(CB_BERASE) |=> s_conf)
        else $error("block erase not followed by confirm");

    chk_multi_data_only: assert property (
        s_opc(CB_MERASE) |-> mode_ff == MODE_DATA ##1 s_conf)
        else $error("multi-block erase outside data mode");

    chk_blank_pair: assert property (
        s_opc(CB_BLANK) |-> mode_ff == MODE_DATA ##1 s_conf)
        else $error("blank check sequence wrong");

    chk_config_seq: assert property (
        s_opc(CB_CONFIG) |-> mode_ff == MODE_CODE
            ##1 (wk_ff == WK_COUNT && wr_data_ff[7:0] == CNT_CONFIG))
        else $error("configuration sequence wrong");

    chk_data_count: assert property (
        (st_ff == ST_CONFIRM && op_ff != OP_BERASE && op_ff != OP_MERASE
         && op_ff != OP_BLANK) |-> cnt_ff == tgt_ff ##1 s_conf)
        else $error("confirm issued with wrong halfword count");

    chk_lock_refuse: assert property (
        (accept && dev_cmd_lock && req_op != OP_CLEAR && req_op != OP_FSTOP
         && req_op != OP_MODE) |=> req_refused_ff && !wr_en_ff)
        else $error("command passed while device locked");

    // a sequence is only started on a ready device, so ready can only
    // come back while the host sits idle
    chk_ready_rise_idle: assert property (
        (dev_ready && !rdy_prev_ff) |-> st_ff == ST_IDLE)
        else $error("device ready rose while a sequence was running");
endmodule // fcs_host_ctrl

// ==== verif/fcs_dev_model.sv ====
// Purpose: behavioural model of the flash sequencer command side
// Assumes: one write per dev_wr_en pulse, synchronous to sys_clk
// Notes:   force_err lets a scenario push the model into command lock
`timescale 1ns/1ps
module fcs_dev_model
    import fcs_pkg::*;
#(
    parameter int BUSY = 20
)(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        force_err,
    input  wire logic        dev_wr_en,
    input  wire logic        dev_wr_mode,
    input  wire logic [15:0] dev_wr_data,
    output logic             dev_ready,
    output logic             dev_cmd_lock
);
    logic [15:0] mode_ff;
    logic [1:0]  seq_ff;
    logic [7:0]  need_ff;
    logic [7:0]  opc_ff;
    logic [7:0]  busy_ff;
    logic        susp_ff;
    logic        err_ff;
    logic [7:0]  b;
    logic [7:0]  ecnt;
    // flags seen by the host
    assign b = dev_wr_data[7:0];
    assign dev_ready = (busy_ff == 8'h00);
    assign dev_cmd_lock = err_ff;
    assign ecnt = (opc_ff == CB_CONFIG) ? CNT_CONFIG :
                  (mode_ff == MODE_CODE) ? CNT_CODE_PROG : CNT_DATA_PROG;
    // mode entry, sequence decode, busy and error tracking
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            mode_ff <= MODE_READ;
            seq_ff <= 2'h0;
            need_ff <= 8'h00;
            opc_ff <= 8'h00;
            busy_ff <= 8'h00;
            susp_ff <= 1'b0;
            err_ff <= 1'b0;
        end
        else
        begin
            if (busy_ff != 8'h00)
                busy_ff <= busy_ff - 8'h01;
            if (force_err)
                err_ff <= 1'b1;
            if (dev_wr_en && dev_wr_mode)
                mode_ff <= dev_wr_data;
            else if (dev_wr_en && mode_ff == MODE_READ)
                err_ff <= 1'b1;
            else if (dev_wr_en && seq_ff == 2'h1)
            begin
                need_ff <= b;
                seq_ff <= 2'h2;
                if (b != ecnt)
                    err_ff <= 1'b1;
            end
            else if (dev_wr_en && seq_ff == 2'h2)
            begin
                need_ff <= need_ff - 8'h01;
                if (need_ff == 8'h01)
                    seq_ff <= 2'h3;
            end
            else if (dev_wr_en && seq_ff == 2'h3)
            begin
                seq_ff <= 2'h0;
                if (b == CB_CONFIRM)
                    busy_ff <= 8'(BUSY);
                else
                    err_ff <= 1'b1;
            end
            else if (dev_wr_en)
            begin
                opc_ff <= b;
                case (b)
                    CB_PROG: seq_ff <= 2'h1;
                    CB_CONFIG:
                        if (mode_ff == MODE_DATA)
                            err_ff <= 1'b1;
                        else
                            seq_ff <= 2'h1;
                    CB_BERASE: seq_ff <= 2'h3;
                    CB_MERASE, CB_BLANK:
                        if (mode_ff == MODE_CODE)
                            err_ff <= 1'b1;
                        else
                            seq_ff <= 2'h3;
                    CB_SUSP: if (busy_ff != 8'h00)
                    begin
                        busy_ff <= 8'h00;
                        susp_ff <= 1'b1;
                    end
                    CB_CONFIRM: if (susp_ff)
                    begin
                        busy_ff <= 8'(BUSY);
                        susp_ff <= 1'b0;
                    end
                    else err_ff <= 1'b1;
                    CB_CLEAR: err_ff <= 1'b0;
                    CB_FSTOP:
                    begin
                        err_ff <= 1'b0;
                        susp_ff <= 1'b0;
                        busy_ff <= 8'h02;
                    end
                    default: err_ff <= 1'b1;
                endcase
            end
        end
    end
endmodule // fcs_dev_model

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench for the flash command host controller
// Assumes: model answers ready 20 cycles after each confirm
// Notes:   every device write is logged and compared in order
`timescale 1ns/1ps
module tb_top;
    import fcs_pkg::*;
    logic        sys_clk = 0, rst = 1, req_valid = 0, wd_valid = 0;
    logic        force_err = 0, req_ready, req_done, req_refused;
    logic        wd_ready, dev_wr_en, dev_wr_mode, dev_ready, dev_cmd_lock;
    logic [3:0]  req_op = 0;
    logic [15:0] req_mode = 0, wd_data = 0, dev_wr_data, cur_mode;
    logic [16:0] exq[$], logq[$];
    int          errors = 0, checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    fcs_host_ctrl fcs_host_ctrl_i (.sys_clk(sys_clk), .rst(rst),
        .req_valid(req_valid), .req_op(req_op), .req_mode(req_mode),
        .req_ready(req_ready), .req_done(req_done), .req_refused(req_refused),
        .wd_valid(wd_valid), .wd_data(wd_data), .wd_ready(wd_ready),
        .dev_wr_en(dev_wr_en), .dev_wr_mode(dev_wr_mode),
        .dev_wr_data(dev_wr_data), .dev_ready(dev_ready),
        .dev_cmd_lock(dev_cmd_lock), .cur_mode(cur_mode));
    fcs_dev_model fcs_dev_model_i (.sys_clk(sys_clk), .rst(rst),
        .force_err(force_err), .dev_wr_en(dev_wr_en),
        .dev_wr_mode(dev_wr_mode), .dev_wr_data(dev_wr_data),
        .dev_ready(dev_ready), .dev_cmd_lock(dev_cmd_lock));
    // log every device write
    always @(posedge sys_clk)
        if (dev_wr_en === 1'b1) logq.push_back({dev_wr_mode, dev_wr_data});
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [16:0] e,
                       input logic [16:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // expected write list: opcode, optional count and halfwords, confirm
    task automatic ex_seq(input logic [7:0] opc, input logic [7:0] cnt);
        exq.push_back({9'h000, opc});
        if (cnt != 8'h00) exq.push_back({9'h000, cnt});
        for (int i = 0; i < cnt; i++) exq.push_back({1'b0, 16'ha000 + 16'(i)});
        exq.push_back({9'h000, CB_CONFIRM});
    endtask
    task automatic run(input logic [3:0] op, input logic [15:0] md,
                       input int n, input logic [1:0] er);
        int i;
        i = 0;
        req_op <= op;
        req_mode <= md;
        req_valid <= 1'b1;
        do @(posedge sys_clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        wd_valid <= (n > 0);
        wd_data <= 16'ha000;
        while (i < n)
        begin
            @(posedge sys_clk);
            if (wd_ready === 1'b1)
            begin
                i++;
                wd_data <= 16'ha000 + 16'(i);
            end
        end
        wd_valid <= 1'b0;
        do @(posedge sys_clk);
        while (!(req_done === 1'b1 || req_refused === 1'b1));
        chk("result", 17'(er), 17'({req_refused, req_done}));
        @(posedge sys_clk);
        chk("write_count", 17'(exq.size()), 17'(logq.size()));
        foreach (exq[k])
            if (k < logq.size()) chk("dev_write", exq[k], logq[k]);
        exq.delete();
        logq.delete();
    endtask
    task automatic wait_rdy();
        repeat (2) @(posedge sys_clk);
        while (dev_ready !== 1'b1) @(posedge sys_clk);
        @(posedge sys_clk);
    endtask
    initial
    begin
        #60000;
        errors++;
        print_verdict();
    end
    // main sequence
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("cur_mode", 17'(MODE_READ), 17'(cur_mode));
        run(OP_BERASE, 0, 0, 2'b10);
        exq.push_back({1'b1, MODE_DATA});
        run(OP_MODE, MODE_DATA, 0, 2'b01);
        chk("cur_mode", 17'(MODE_DATA), 17'(cur_mode));
        run(OP_MODE, MODE_DATA, 0, 2'b01);
        ex_seq(CB_PROG, CNT_DATA_PROG);
        run(OP_PROG, 0, 2, 2'b01);
        repeat (2) @(posedge sys_clk);
        chk("dev_ready", 17'h0, 17'(dev_ready));
        run(OP_BERASE, 0, 0, 2'b10);
        exq.push_back({9'h000, CB_SUSP});
        run(OP_SUSP, 0, 0, 2'b01);
        exq.push_back({9'h000, CB_CONFIRM});
        run(OP_RESUME, 0, 0, 2'b01);
        wait_rdy();
        ex_seq(CB_MERASE, 8'h00);
        run(OP_MERASE, 0, 0, 2'b01);
        wait_rdy();
        ex_seq(CB_BLANK, 8'h00);
        run(OP_BLANK, 0, 0, 2'b01);
        wait_rdy();
        run(OP_CONFIG, 0, 0, 2'b10);
        exq.push_back({1'b1, MODE_CODE});
        run(OP_MODE, MODE_CODE, 0, 2'b01);
        ex_seq(CB_PROG, CNT_CODE_PROG);
        run(OP_PROG, 0, 64, 2'b01);
        wait_rdy();
        ex_seq(CB_CONFIG, CNT_CONFIG);
        run(OP_CONFIG, 0, 8, 2'b01);
        wait_rdy();
        ex_seq(CB_BERASE, 8'h00);
        run(OP_BERASE, 0, 0, 2'b01);
        wait_rdy();
        run(OP_MERASE, 0, 0, 2'b10);
        run(OP_BLANK, 0, 0, 2'b10);
        force_err <= 1'b1;
        @(posedge sys_clk);
        force_err <= 1'b0;
        run(OP_PROG, 0, 0, 2'b10);
        exq.push_back({9'h000, CB_CLEAR});
        run(OP_CLEAR, 0, 0, 2'b01);
        chk("lock", 17'h0, 17'(dev_cmd_lock));
        chk("dev_ready", 17'h1, 17'(dev_ready));
        // forced stop must still pass while the device is locked
        force_err <= 1'b1;
        @(posedge sys_clk);
        force_err <= 1'b0;
        exq.push_back({9'h000, CB_FSTOP});
        run(OP_FSTOP, 0, 0, 2'b01);
        chk("lock", 17'h0, 17'(dev_cmd_lock));
        wait_rdy();
        run(OP_MODE, 16'h1234, 0, 2'b10);
        run(4'ha, 0, 0, 2'b10);
        print_verdict();
    end
endmodule // tb_top
